// ---- test/dacuc_ctrl_monitor.sv ----
// assertion checker on the dac update control ports
`timescale 1ns/1ps
`include "dacuc_defs.vh"
module dacuc_mon #(
   parameter INIT_CYC = 200
) (
   input wire core_clk,
   input wire srst,
   input wire reset_pin_n,
   input wire output_clear_n,
   input wire wr_valid,
   input wire wr_ready,
   input wire [2:0] wr_kind,
   input wire [15:0] wr_chan_mask,
   input wire [15:0] wr_data,
   input wire busy_n_oe,
   input wire gpio_out,
   input wire gpio_oe,
   input wire [15:0] gpio_read_word,
   input wire [5:0] output_monitor_select,
   input wire monitor_output_en,
   input wire outputs_grounded,
   input wire init_active,
   input wire dac_upd_valid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   reg [9:0] bcnt_reg;
   reg [6:0] ccnt_reg;
   reg [15:0] icnt_reg;
   wire take = wr_valid && wr_ready;
   // run lengths of busy, clear low and init
   always @(posedge core_clk) begin
      bcnt_reg <= (srst || !busy_n_oe) ? 10'h000 : bcnt_reg + 10'h001;
      if (srst || output_clear_n)
         ccnt_reg <= 7'h00;
      else if (ccnt_reg != 7'h50)
         ccnt_reg <= ccnt_reg + 7'h01;
      icnt_reg <= (srst || !reset_pin_n || !init_active) ? 16'h0000 :
         icnt_reg + 16'h0001;
   end
   AST_BUSY_ON: assert property (
      take && wr_kind < 3'h3 && |wr_chan_mask |=> busy_n_oe)
      else $error("busy not raised by calc write");
   AST_BUSY_MAX: assert property (bcnt_reg < 10'd880)
      else $error("busy held too long");
   AST_MON_EN: assert property (
      monitor_output_en == output_monitor_select[5])
      else $error("monitor enable mismatch");
   AST_MON_WR: assert property (
      take && wr_kind == `DACUC_WK_MONITOR |=>
      output_monitor_select == $past(wr_data[5:0]))
      else $error("monitor write lost");
   AST_GPIO_WR: assert property (
      take && wr_kind == `DACUC_WK_GPIO |=> gpio_oe == $past(wr_data[1])
      && (!gpio_oe || gpio_out == $past(wr_data[0])))
      else $error("gpio config wrong");
   AST_GPIO_RD: assert property (
      gpio_read_word[15:1] == 15'h0000)
      else $error("gpio read upper bits set");
   AST_INIT_QUIET: assert property (
      init_active |-> !wr_ready && !dac_upd_valid && outputs_grounded)
      else $error("activity during init");
   AST_INIT_LEN: assert property (icnt_reg <= INIT_CYC + 4)
      else $error("init sequence too long");
   AST_CLR_GND: assert property (
      !output_clear_n [*5] |-> outputs_grounded)
      else $error("clear did not ground");
   AST_CLR_NOLD: assert property (
      ccnt_reg == 7'h50 |-> !dac_upd_valid)
      else $error("load taken under clear");
endmodule // dacuc_mon
bind dacuc_ctrl dacuc_mon #(.INIT_CYC(INIT_CYC)) dacuc_mon_i (
   .core_clk(core_clk), .srst(srst), .reset_pin_n(reset_pin_n),
   .output_clear_n(output_clear_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .wr_kind(wr_kind), .wr_chan_mask(wr_chan_mask), .wr_data(wr_data),
   .busy_n_oe(busy_n_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
   .gpio_read_word(gpio_read_word),
   .output_monitor_select(output_monitor_select),
   .monitor_output_en(monitor_output_en), .outputs_grounded(outputs_grounded),
   .init_active(init_active), .dac_upd_valid(dac_upd_valid));

// ---- test/dacuc_ctrl_test.sv ----
// self-checking bench for the dac update control block
`timescale 1ns/1ps
`include "dacuc_defs.vh"
module dacuc_ctrl_test;
   reg core_clk = 1'b0;
   reg srst = 1'b1;
   reg rst_n = 1'b1, clr_n = 1'b1, ld_n = 1'b1, fmt = 1'b0;
   reg gpio_drv = 1'b0, hold = 1'b0, wr_valid = 1'b0, wr_ab = 1'b0;
   reg [2:0] wr_kind = 3'h0;
   reg [15:0] wr_mask = 16'h0000, wr_data = 16'h0000;
   reg [15:0] upd_n = 16'h0000, base = 16'h0000, last_code = 16'h0000;
   reg [3:0] last_ch = 4'h0;
   integer error_cnt = 0, checks = 0, cyc = 0, blen = 0, bcnt = 0;
   wire busy_oe, busy_o, peer_oe, gpio_out, gpio_oe, wr_ready, grounded;
   wire init_act, upd_v, mon_en, mon_ri, mon_is;
   wire [15:0] gpio_rd, ab_sel, upd_code;
   wire [5:0] mon_sel;
   wire [3:0] mon_ch, upd_ch;
   wire [13:0] ofs0, ofs1;
   // shared wires with pull-up and pin resolution
   wire busy_w = !((busy_oe && !busy_o) || peer_oe);
   wire gpio_w = gpio_oe ? gpio_out : gpio_drv;
   always #10 core_clk = ~core_clk;
   dacuc_ctrl #(.INIT_CYC(200)) dacuc_ctrl_i (
      .core_clk(core_clk), .srst(srst), .reset_pin_n(rst_n),
      .output_clear_n(clr_n), .load_strobe_n(ld_n), .data_format_sel(fmt),
      .busy_n_in(busy_w), .busy_n_out(busy_o), .busy_n_oe(busy_oe),
      .gpio_in(gpio_w), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .wr_valid(wr_valid), .wr_kind(wr_kind), .wr_chan_mask(wr_mask),
      .wr_ab(wr_ab), .wr_data(wr_data), .wr_ready(wr_ready),
      .gpio_read_word(gpio_rd), .output_monitor_select(mon_sel),
      .monitor_output_en(mon_en), .monitor_route_input(mon_ri),
      .monitor_chan_sel(mon_ch), .monitor_input_sel(mon_is),
      .ab_select(ab_sel), .offset_dac_0(ofs0), .offset_dac_1(ofs1),
      .outputs_grounded(grounded), .init_active(init_act),
      .dac_upd_valid(upd_v), .dac_upd_chan(upd_ch), .dac_upd_code(upd_code));
   dacuc_peer dacuc_peer_i (.core_clk(core_clk), .hold(hold),
      .busy_n_oe(peer_oe));
   // cycle limit, busy length and update tally
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (busy_oe)
         bcnt <= bcnt + 1;
      else if (bcnt != 0) begin
         blen <= bcnt;
         bcnt <= 0;
      end
      if (upd_v === 1'b1) begin
         upd_n <= upd_n + 16'h0001;
         last_code <= upd_code;
         last_ch <= upd_ch;
      end
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         conclude;
      end
   end
   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         checks = checks + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [2:0] k, input [15:0] m, input ab, input [15:0] d);
      begin
         @(negedge core_clk);
         wr_kind = k;
         wr_mask = m;
         wr_ab = ab;
         wr_data = d;
         wr_valid = 1'b1;
         #1;
         while (wr_ready !== 1'b1) @(negedge core_clk);
         @(negedge core_clk);
         wr_valid = 1'b0;
      end
   endtask
   task idle(input integer n);
      repeat (n) @(negedge core_clk);
   endtask
   task bwait;
      begin
         idle(3);
         while (busy_w !== 1'b1) @(negedge core_clk);
         idle(2);
      end
   endtask
   task ld;
      begin
         @(negedge core_clk);
         ld_n = 1'b0;
         idle(3);
         ld_n = 1'b1;
      end
   endtask
   task lchk(input [15:0] n, input [15:0] c);
      begin
         idle(60);
         chk("updates", n, upd_n - base);
         if (n != 16'h0000)
            chk("code", c, last_code);
         base = upd_n;
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", checks, error_cnt);
         if (error_cnt == 0 && checks > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // main sequence
   initial begin
      repeat (6) @(negedge core_clk);
      srst = 1'b0;
      while (wr_ready !== 1'b1) @(negedge core_clk);
      chk("mon", 16'h0000, {10'h000, mon_sel});
      chk("ofs0", 16'h2000, {2'h0, ofs0});
      chk("gnd", 16'h0001, {15'h0000, grounded});
      wr(`DACUC_WK_MONITOR, 16'h0000, 1'b0, 16'h002f);
      chk("mch", 16'h001f, {11'h000, mon_en, mon_ch});
      wr(`DACUC_WK_MONITOR, 16'h0000, 1'b0, 16'h0031);
      chk("min", 16'h0007, {13'h0000, mon_en, mon_ri, mon_is});
      wr(`DACUC_WK_MONITOR, 16'h0000, 1'b0, 16'h0011);
      chk("moff", 16'h0000, {15'h0000, mon_en});
      wr(`DACUC_WK_GPIO, 16'h0000, 1'b0, 16'h0003);
      chk("gpo", 16'h0003, {14'h0000, gpio_oe, gpio_out});
      wr(`DACUC_WK_GPIO, 16'h0000, 1'b0, 16'h0000);
      gpio_drv = 1'b1;
      idle(4);
      chk("gpi", 16'h0001, gpio_rd);
      wr(`DACUC_WK_ABSEL0, 16'h0000, 1'b0, 16'h00a5);
      wr(`DACUC_WK_ABSEL1, 16'h0000, 1'b0, 16'h003c);
      chk("ab", 16'h3ca5, ab_sel);
      $display("side registers done");
      wr(`DACUC_WK_INPUT, 16'h0008, 1'b0, 16'h1234);
      bwait;
      chk("busy1", 16'h0001, {15'h0, blen > 0 && blen < 63});
      wr(`DACUC_WK_INPUT, 16'hffff, 1'b0, 16'h4000);
      bwait;
      chk("busy16", 16'h0001, {15'h0000, blen <= 437});
      ld;
      lchk(16'h0008, 16'h4000);
      chk("gnd", 16'h0000, {15'h0000, grounded});
      ld;
      lchk(16'h0000, 16'h0000);
      fmt = 1'b1;
      idle(3);
      wr(`DACUC_WK_INPUT, 16'h0001, 1'b1, 16'h1000);
      bwait;
      ld;
      lchk(16'h0001, 16'h9000);
      fmt = 1'b0;
      idle(3);
      $display("load paths done");
      wr(`DACUC_WK_INPUT, 16'h0002, 1'b0, 16'h0777);
      hold = 1'b1;
      ld;
      idle(40);
      lchk(16'h0000, 16'h0000);
      hold = 1'b0;
      lchk(16'h0001, 16'h0777);
      ld_n = 1'b0;
      idle(60);
      base = upd_n;
      wr(`DACUC_WK_INPUT, 16'h0002, 1'b0, 16'h0555);
      bwait;
      lchk(16'h0001, 16'h0555);
      ld_n = 1'b1;
      $display("busy and deferred load done");
      clr_n = 1'b0;
      idle(8);
      chk("clr", 16'h0001, {15'h0000, grounded});
      wr(`DACUC_WK_OFSDAC, 16'h0101, 1'b0, 16'h1abc);
      chk("ofs0", 16'h1abc, {2'h0, ofs0});
      chk("ofs1", 16'h1abc, {2'h0, ofs1});
      wr(`DACUC_WK_INPUT, 16'h0002, 1'b0, 16'h0666);
      bwait;
      ld;
      lchk(16'h0000, 16'h0000);
      clr_n = 1'b1;
      idle(40);
      chk("clrhi", 16'h0001, {15'h0000, grounded});
      ld;
      lchk(16'h0001, 16'h0666);
      chk("lift", 16'h0000, {15'h0000, grounded});
      wr(`DACUC_WK_GAIN, 16'h0002, 1'b0, 16'h7fff);
      bwait;
      ld;
      lchk(16'h0001, 16'h0333);
      chk("chan", 16'h0001, {12'h000, last_ch});
      $display("clear done");
      rst_n = 1'b0;
      idle(5);
      chk("rst", 16'h0003, {14'h0000, init_act, grounded});
      rst_n = 1'b1;
      idle(3);
      while (wr_ready !== 1'b1) @(negedge core_clk);
      chk("rofs", 16'h2000, {2'h0, ofs1});
      ld;
      lchk(16'h0000, 16'h0000);
      chk("rgnd", 16'h0001, {15'h0000, grounded});
      $display("reset pin done");
      conclude;
   end
endmodule // dacuc_ctrl_test

// ---- test/dacuc_peer.sv ----
// second device sharing the open-drain busy wire
`timescale 1ns/1ps
module dacuc_peer (
   input wire core_clk,
   input wire hold,
   output reg busy_n_oe = 1'b0
);
   // pull the wire low while its own work is pending
   always @(posedge core_clk) begin
      busy_n_oe <= hold;
   end
endmodule // dacuc_peer

// ---- verilog/dacuc_ctrl.v ----
// dac update control: reset sequence, clear, busy, load and side registers
`timescale 1ns/1ps
`include "dacuc_defs.vh"

module dacuc_ctrl #(
   parameter INIT_CYC = `DACUC_INIT_CYC
) (
   input wire core_clk,
   input wire srst,
   input wire reset_pin_n,
   input wire output_clear_n,
   input wire load_strobe_n,
   input wire data_format_sel,
   input wire busy_n_in,
   output wire busy_n_out,
   output wire busy_n_oe,
   input wire gpio_in,
   output wire gpio_out,
   output wire gpio_oe,
   input wire wr_valid,
   input wire [2:0] wr_kind,
   input wire [15:0] wr_chan_mask,
   input wire wr_ab,
   input wire [15:0] wr_data,
   output wire wr_ready,
   output wire [15:0] gpio_read_word,
   output wire [5:0] output_monitor_select,
   output wire monitor_output_en,
   output wire monitor_route_input,
   output wire [3:0] monitor_chan_sel,
   output wire monitor_input_sel,
   output wire [15:0] ab_select,
   output wire [13:0] offset_dac_0,
   output wire [13:0] offset_dac_1,
   output wire outputs_grounded,
   output wire init_active,
   output wire dac_upd_valid,
   output wire [3:0] dac_upd_chan,
   output wire [15:0] dac_upd_code
);
   localparam ST_HOLD = 3'h0;
   localparam ST_INIT = 3'h1;
   localparam ST_IDLE = 3'h2;
   localparam ST_CALC = 3'h3;
   localparam ST_TAIL = 3'h4;
   localparam ST_LOAD = 3'h5;
   // tail one cycle short: the held-write cycle already counts as busy
   localparam integer STAGE_I = `DACUC_STAGE_CYC - 1;
   localparam integer TAIL_I = `DACUC_STAGE_CYC + `DACUC_TAIL_CYC - 2;
   localparam integer INIT_I = INIT_CYC - 1;
   localparam [4:0] STAGE_LAST = STAGE_I[4:0];
   localparam [5:0] TAIL_LAST = TAIL_I[5:0];
   localparam [15:0] INIT_LAST = INIT_I[15:0];

   wire [5:0] pins_sync;
   wire rst_pin_s;
   wire clr_s;
   wire load_s;
   wire busy_line_s;
   wire gpio_s;
   wire fmt_s;
   wire [15:0] mem_rdata;
   reg mem_we;
   reg [6:0] mem_addr;
   reg [15:0] mem_wdata;

   reg [2:0] state_reg;
   reg [15:0] cnt_reg;
   reg [4:0] step_reg;
   reg [3:0] chan_reg;
   reg rst_pin_d_reg;
   reg load_d_reg;
   reg busy_line_d_reg;
   reg load_pend_reg;
   reg ground_reg;
   reg need_change_reg;
   reg hold_valid_reg;
   reg [2:0] hold_kind_reg;
   reg [15:0] hold_mask_reg;
   reg hold_ab_reg;
   reg [15:0] hold_data_reg;
   reg [2:0] job_kind_reg;
   reg [15:0] job_mask_reg;
   reg job_ab_reg;
   reg [15:0] job_data_reg;
   reg [15:0] cap_x1_reg;
   reg [15:0] cap_m_reg;
   reg [15:0] chg_a_reg;
   reg [15:0] chg_b_reg;
   reg [15:0] ab_sel_reg;
   reg [5:0] mon_reg;
   reg [1:0] gpio_reg;
   reg [13:0] ofs0_reg;
   reg [13:0] ofs1_reg;
   reg upd_valid_reg;
   reg [3:0] upd_chan_reg;
   reg [15:0] upd_code_reg;

   // pins from outside pass two flip-flops
   dacuc_sync #(.WIDTH(6)) u_sync (
      .core_clk(core_clk),
      .srst(srst),
      .async_in({data_format_sel, gpio_in, busy_n_in,
                 load_strobe_n, output_clear_n, reset_pin_n}),
      .rst_val(6'h1f),
      .sync_out(pins_sync)
   );
   assign rst_pin_s = pins_sync[0];
   assign clr_s = pins_sync[1];
   assign load_s = pins_sync[2];
   assign busy_line_s = pins_sync[3];
   assign gpio_s = pins_sync[4];
   // format resets to binary, the other pins to their idle high
   assign fmt_s = pins_sync[5];

   dacuc_mem u_mem (
      .core_clk(core_clk),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // lowest pending channel of a mask
   function [4:0] first_chan;
      input [15:0] mask;
      integer k;
      begin
         first_chan = 5'h10;
         for (k = 15; k >= 0; k = k - 1) begin
            if (mask[k]) begin
               first_chan = k[4:0];
            end
         end
      end
   endfunction

   // twos complement input turned into offset binary
   wire conv = fmt_s && (wr_kind == `DACUC_WK_INPUT ||
      wr_kind == `DACUC_WK_OFFSET);
   wire [15:0] wr_conv = {wr_data[15] ^ conv, wr_data[14:0]};
   wire ofs_conv = fmt_s && (wr_kind == `DACUC_WK_OFSDAC);
   wire [13:0] ofs_val = {wr_data[13] ^ ofs_conv, wr_data[12:0]};
   wire calc_kind = (wr_kind == `DACUC_WK_INPUT) ||
      (wr_kind == `DACUC_WK_GAIN) || (wr_kind == `DACUC_WK_OFFSET);
   wire live = (state_reg != ST_HOLD) && (state_reg != ST_INIT);
   assign wr_ready = live && (!calc_kind || !hold_valid_reg);
   wire wr_take = wr_valid && wr_ready;
   wire own_busy = hold_valid_reg || state_reg == ST_CALC ||
      state_reg == ST_TAIL;

   // recalculated code: x1 * (m + 1) / 2^16 + c - 2^15, saturated
   wire [32:0] prod = cap_x1_reg * ({1'b0, cap_m_reg} + 17'h00001);
   wire [18:0] sum = {2'b00, prod[32:16]} + {3'b000, mem_rdata} -
      `DACUC_MID_SCALE;
   wire [15:0] x2_val = sum[18] ? 16'h0000 :
      (sum[17:16] != 2'b00) ? 16'hffff : sum[15:0];
   wire [4:0] next_chan = first_chan(job_mask_reg & ~(16'h0001 << chan_reg));
   wire [4:0] hold_first = first_chan(hold_mask_reg);
   wire x1_fld_b = job_ab_reg;
   wire [2:0] job_fld = (job_kind_reg == `DACUC_WK_GAIN) ? `DACUC_FLD_GAIN :
      (job_kind_reg == `DACUC_WK_OFFSET) ? `DACUC_FLD_OFFS :
      (x1_fld_b ? `DACUC_FLD_X1B : `DACUC_FLD_X1A);
   wire load_sel_b = ab_sel_reg[chan_reg];
   wire load_chg = load_sel_b ? chg_b_reg[chan_reg] : chg_a_reg[chan_reg];
   wire busy_rise = busy_line_s && !busy_line_d_reg;
   wire load_fall = !load_s && load_d_reg;

   // memory port steering per state
   always @* begin
      mem_we = 1'b0;
      mem_addr = {`DACUC_FLD_X1A, chan_reg};
      mem_wdata = `DACUC_RST_X1;
      case (state_reg)
         ST_INIT: begin
            mem_we = (cnt_reg < 16'h0070);
            mem_addr = cnt_reg[6:0];
            case (cnt_reg[6:4])
               `DACUC_FLD_GAIN: mem_wdata = `DACUC_RST_GAIN;
               `DACUC_FLD_OFFS: mem_wdata = `DACUC_RST_OFFS;
               `DACUC_FLD_X1A, `DACUC_FLD_X1B: mem_wdata = `DACUC_RST_X1;
               default: mem_wdata = `DACUC_RST_X2;
            endcase
         end
         ST_CALC: begin
            case (step_reg)
               5'h00: begin
                  mem_we = 1'b1;
                  mem_addr = {job_fld, chan_reg};
                  mem_wdata = job_data_reg;
               end
               5'h01: mem_addr = {(job_ab_reg ? `DACUC_FLD_X1B :
                  `DACUC_FLD_X1A), chan_reg};
               5'h02: mem_addr = {`DACUC_FLD_GAIN, chan_reg};
               5'h03: mem_addr = {`DACUC_FLD_OFFS, chan_reg};
               5'h04: begin
                  mem_we = 1'b1;
                  mem_addr = {(job_ab_reg ? `DACUC_FLD_X2B :
                     `DACUC_FLD_X2A), chan_reg};
                  mem_wdata = x2_val;
               end
               default: mem_addr = {`DACUC_FLD_X1A, chan_reg};
            endcase
         end
         ST_LOAD: begin
            mem_we = step_reg[0] && load_chg;
            mem_addr = step_reg[0] ? {`DACUC_FLD_DAC, chan_reg} :
               {(load_sel_b ? `DACUC_FLD_X2B : `DACUC_FLD_X2A),
               chan_reg};
            mem_wdata = mem_rdata;
         end
         default: mem_addr = {`DACUC_FLD_X1A, chan_reg};
      endcase
   end

   // main sequencer: init, recalculation, busy tail and load
   always @(posedge core_clk) begin
      if (srst) begin
         state_reg <= ST_INIT;
         cnt_reg <= 16'h0000;
         step_reg <= 5'h00;
         chan_reg <= 4'h0;
         job_kind_reg <= `DACUC_WK_INPUT;
         job_mask_reg <= 16'h0000;
         job_ab_reg <= 1'b0;
         job_data_reg <= 16'h0000;
         cap_x1_reg <= 16'h0000;
         cap_m_reg <= 16'h0000;
         hold_valid_reg <= 1'b0;
         hold_kind_reg <= 3'h0;
         hold_mask_reg <= 16'h0000;
         hold_ab_reg <= 1'b0;
         hold_data_reg <= 16'h0000;
         chg_a_reg <= 16'h0000;
         chg_b_reg <= 16'h0000;
         upd_valid_reg <= 1'b0;
         upd_chan_reg <= 4'h0;
         upd_code_reg <= 16'h0000;
      end else begin
         upd_valid_reg <= 1'b0;
         if (wr_take && calc_kind && wr_chan_mask != 16'h0000) begin
            hold_valid_reg <= 1'b1;
            hold_kind_reg <= wr_kind;
            hold_mask_reg <= wr_chan_mask;
            hold_ab_reg <= wr_ab;
            hold_data_reg <= wr_conv;
         end
         if (!rst_pin_s) begin
            state_reg <= ST_HOLD;
            hold_valid_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_HOLD: begin
                  if (!rst_pin_d_reg) begin
                     state_reg <= ST_INIT;
                     cnt_reg <= 16'h0000;
                  end
               end
               ST_INIT: begin
                  cnt_reg <= cnt_reg + 16'h0001;
                  chg_a_reg <= 16'h0000;
                  chg_b_reg <= 16'h0000;
                  if (cnt_reg >= INIT_LAST) begin
                     state_reg <= ST_IDLE;
                  end
               end
               ST_IDLE: begin
                  if (hold_valid_reg) begin
                     state_reg <= ST_CALC;
                     hold_valid_reg <= 1'b0;
                     job_kind_reg <= hold_kind_reg;
                     job_mask_reg <= hold_mask_reg;
                     job_ab_reg <= hold_ab_reg;
                     job_data_reg <= hold_data_reg;
                     chan_reg <= hold_first[3:0];
                     step_reg <= 5'h00;
                  end else if (load_pend_reg && busy_line_s) begin
                     state_reg <= ST_LOAD;
                     chan_reg <= 4'h0;
                     step_reg <= 5'h00;
                  end
               end
               ST_CALC: begin
                  step_reg <= step_reg + 5'h01;
                  if (step_reg == 5'h02) begin
                     cap_x1_reg <= mem_rdata;
                  end
                  if (step_reg == 5'h03) begin
                     cap_m_reg <= mem_rdata;
                  end
                  if (step_reg == 5'h04) begin
                     if (job_ab_reg) begin
                        chg_b_reg[chan_reg] <= 1'b1;
                     end else begin
                        chg_a_reg[chan_reg] <= 1'b1;
                     end
                  end
                  if (step_reg == STAGE_LAST) begin
                     step_reg <= 5'h00;
                     if (!next_chan[4]) begin
                        chan_reg <= next_chan[3:0];
                        job_mask_reg[chan_reg] <= 1'b0;
                     end else begin
                        state_reg <= ST_TAIL;
                        cnt_reg <= 16'h0000;
                     end
                  end
               end
               ST_TAIL: begin
                  cnt_reg <= cnt_reg + 16'h0001;
                  if (cnt_reg[5:0] >= TAIL_LAST) begin
                     state_reg <= ST_IDLE;
                  end
               end
               ST_LOAD: begin
                  step_reg <= {4'h0, ~step_reg[0]};
                  if (step_reg[0]) begin
                     if (load_chg) begin
                        upd_valid_reg <= 1'b1;
                        upd_chan_reg <= chan_reg;
                        upd_code_reg <= mem_rdata;
                        if (load_sel_b) begin
                           chg_b_reg[chan_reg] <= 1'b0;
                        end else begin
                           chg_a_reg[chan_reg] <= 1'b0;
                        end
                     end
                     chan_reg <= chan_reg + 4'h1;
                     if (chan_reg == 4'hf) begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // edge history, stored load, output grounding
   always @(posedge core_clk) begin
      if (srst) begin
         rst_pin_d_reg <= 1'b1;
         load_d_reg <= 1'b1;
         busy_line_d_reg <= 1'b1;
         load_pend_reg <= 1'b0;
         ground_reg <= 1'b1;
         need_change_reg <= 1'b1;
      end else begin
         rst_pin_d_reg <= rst_pin_s;
         load_d_reg <= load_s;
         busy_line_d_reg <= busy_line_s;
         if (!rst_pin_s || state_reg == ST_INIT) begin
            ground_reg <= 1'b1;
            need_change_reg <= 1'b1;
            load_pend_reg <= 1'b0;
         end else if (!clr_s) begin
            ground_reg <= 1'b1;
            load_pend_reg <= 1'b0;
         end else begin
            // a changed channel reaching its dac ends the reset grounding
            if (state_reg == ST_LOAD && step_reg[0] && load_chg) begin
               need_change_reg <= 1'b0;
            end
            if (state_reg == ST_LOAD && step_reg[0] && chan_reg == 4'hf) begin
               load_pend_reg <= 1'b0;
               if (!need_change_reg || load_chg) begin
                  ground_reg <= 1'b0;
               end
            end
            // a new event wins over the completion clear
            if (load_fall || (!load_s && busy_rise)) begin
               load_pend_reg <= 1'b1;
            end
         end
      end
   end

   // side registers: a/b select, offset dacs, monitor, gpio
   always @(posedge core_clk) begin
      if (srst || state_reg == ST_INIT) begin
         ab_sel_reg <= 16'h0000;
         ofs0_reg <= `DACUC_RST_OFSDAC;
         ofs1_reg <= `DACUC_RST_OFSDAC;
         mon_reg <= `DACUC_RST_MON;
         gpio_reg <= `DACUC_RST_GPIO;
      end else if (wr_take) begin
         case (wr_kind)
            `DACUC_WK_ABSEL0: ab_sel_reg[7:0] <= wr_data[7:0];
            `DACUC_WK_ABSEL1: ab_sel_reg[15:8] <= wr_data[7:0];
            `DACUC_WK_OFSDAC: begin
               if (wr_chan_mask[0]) begin
                  ofs0_reg <= ofs_val;
               end
               if (wr_chan_mask[8]) begin
                  ofs1_reg <= ofs_val;
               end
            end
            `DACUC_WK_MONITOR: mon_reg <= wr_data[5:0];
            `DACUC_WK_GPIO: gpio_reg <= wr_data[1:0];
            default: mon_reg <= mon_reg;
         endcase
      end
   end

   // busy is open drain: pulled low while own work runs
   assign busy_n_out = 1'b0;
   assign busy_n_oe = own_busy;
   assign gpio_oe = gpio_reg[`DACUC_PIN_DIR_BIT];
   assign gpio_out = gpio_reg[`DACUC_PIN_LVL_BIT];
   assign gpio_read_word = {15'h0000, gpio_s};
   assign output_monitor_select = mon_reg;
   assign monitor_output_en = mon_reg[`DACUC_MON_EN_BIT];
   assign monitor_route_input = mon_reg[`DACUC_MON_SRC_BIT];
   assign monitor_chan_sel = mon_reg[3:0];
   assign monitor_input_sel = mon_reg[0];
   assign ab_select = ab_sel_reg;
   assign offset_dac_0 = ofs0_reg;
   assign offset_dac_1 = ofs1_reg;
   // clear grounds the outputs and drops pending loads; stored data stays
   assign outputs_grounded = ground_reg;
   assign init_active = (state_reg == ST_INIT) || (state_reg == ST_HOLD);
   assign dac_upd_valid = upd_valid_reg;
   assign dac_upd_chan = upd_chan_reg;
   assign dac_upd_code = upd_code_reg;
endmodule // dacuc_ctrl

// ---- verilog/dacuc_defs.vh ----
// constants shared by the dac update control block
`ifndef DACUC_DEFS_VH
`define DACUC_DEFS_VH

// timing, clock at 50 mhz
`define DACUC_CLK_MHZ 50
`define DACUC_STAGE_NS 500
`define DACUC_TAIL_NS 250
`define DACUC_INIT_US 300
`define DACUC_STAGE_CYC ((`DACUC_STAGE_NS * `DACUC_CLK_MHZ) / 1000)
`define DACUC_TAIL_CYC ((`DACUC_TAIL_NS * `DACUC_CLK_MHZ) / 1000)
`define DACUC_INIT_CYC (`DACUC_INIT_US * `DACUC_CLK_MHZ)

// write kinds on the written-register strobe
`define DACUC_WK_INPUT 3'h0
`define DACUC_WK_GAIN 3'h1
`define DACUC_WK_OFFSET 3'h2
`define DACUC_WK_ABSEL0 3'h3
`define DACUC_WK_ABSEL1 3'h4
`define DACUC_WK_OFSDAC 3'h5
`define DACUC_WK_MONITOR 3'h6
`define DACUC_WK_GPIO 3'h7

// coefficient memory fields, address is {field, channel}
`define DACUC_FLD_X1A 3'h0
`define DACUC_FLD_X1B 3'h1
`define DACUC_FLD_GAIN 3'h2
`define DACUC_FLD_OFFS 3'h3
`define DACUC_FLD_X2A 3'h4
`define DACUC_FLD_X2B 3'h5
`define DACUC_FLD_DAC 3'h6

// reset values
`define DACUC_RST_X1 16'h8000
`define DACUC_RST_GAIN 16'hffff
`define DACUC_RST_OFFS 16'h8000
`define DACUC_RST_X2 16'h8000
`define DACUC_RST_OFSDAC 14'h2000
`define DACUC_RST_MON 6'h00
`define DACUC_RST_GPIO 2'h0
`define DACUC_MID_SCALE 19'h08000

// monitor and gpio field positions
`define DACUC_MON_EN_BIT 5
`define DACUC_MON_SRC_BIT 4
`define DACUC_PIN_DIR_BIT 1
`define DACUC_PIN_LVL_BIT 0

`endif

// ---- verilog/dacuc_mem.v ----
// per-channel coefficient and data memory with registered read
`timescale 1ns/1ps
module dacuc_mem (
   input wire core_clk,
   input wire we,
   input wire [6:0] addr,
   input wire [15:0] wdata,
   output reg [15:0] rdata
);
   reg [15:0] mem [0:127];
   // single port, read data one cycle after the address
   always @(posedge core_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule // dacuc_mem

// ---- verilog/dacuc_sync.v ----
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module dacuc_sync #(
   parameter WIDTH = 6
) (
   input wire core_clk,
   input wire srst,
   input wire [WIDTH-1:0] async_in,
   input wire [WIDTH-1:0] rst_val,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;
   genvar i;
   // one chain per bit, first stage read only by the second
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge core_clk) begin
            if (srst) begin
               meta_reg[i] <= rst_val[i];
               sync_reg[i] <= rst_val[i];
            end else begin
               meta_reg[i] <= async_in[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
   assign sync_out = sync_reg;
endmodule // dacuc_sync
